// file: rtl/sac_pkg.sv
package sac_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_RES_LO = 8'h04;
  localparam logic [7:0] IDX_RES_HI = 8'h05;
  localparam logic [7:0] IDX_CSR = 8'h06;
  localparam logic [7:0] IDX_MUX = 8'h07;
  localparam int unsigned ADDR_STEP = 4;

  // ==========================================================
  // Control/status field positions
  localparam int unsigned CSR_ON = 7;
  localparam int unsigned CSR_GO = 6;
  localparam int unsigned CSR_FREE = 5;
  localparam int unsigned CSR_DONE = 4;
  localparam int unsigned CSR_IE = 3;
  localparam int unsigned CSR_PS_HI = 2;

  // ==========================================================
  // Input/reference select field positions
  localparam int unsigned MUX_REF_HI = 7;
  localparam int unsigned MUX_REF_LO = 6;
  localparam int unsigned MUX_LJ = 5;
  localparam int unsigned MUX_SEL_HI = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] MUX_RST = 8'h00;

  // ==========================================================
  // Conversion timing in converter clock cycles; result and prescaler counter widths in bits
  localparam int unsigned NORM_LEN = 13;
  localparam int unsigned EXT_LEN = 25;
  localparam int unsigned NORM_SH = 1;
  localparam int unsigned EXT_SH = 13;
  localparam int unsigned RES_W = 10;
  localparam int unsigned PS_W = 7;

  typedef enum logic {
    SAC_IDLE,
    SAC_RUN
  } sac_state_t;

endpackage

// file: rtl/sac_conv_if.sv
`timescale 1ns/1ns
interface sac_conv_if;
  logic en;
  logic [2:0] sel;
  logic rise;
  logic fall;
  logic load;
  logic step;
  logic cmp;
  logic [9:0] code;

  modport pre (input en, input sel, output rise, output fall);
  modport sar (input load, input step, input cmp, output code);
  modport ctl (
    output en, output sel, output load, output step, output cmp,
    input rise, input fall, input code
  );
endinterface

// file: rtl/sac_prescaler.sv
`timescale 1ns/1ns
module sac_prescaler
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_ni,
  sac_conv_if.pre cv
);

  typedef struct packed {
    logic [PS_W-1:0] cnt;
    logic rise;
    logic fall;
  } sac_pre_t;

  sac_pre_t s;
  sac_pre_t d;
  logic [2:0] lg;
  logic [PS_W-1:0] top;

  // ==========================================================
  // Divider: pulses mark converter clock edges
  always_comb begin
    d = s;
    d.rise = 1'b0;
    d.fall = 1'b0;
    lg = (cv.sel == 3'h0) ? 3'h1 : cv.sel;
    top = PS_W'((8'h01 << lg) - 8'h01);
    if (!cv.en) begin
      d.cnt = '0;
    end else if (s.cnt == top) begin
      d.cnt = '0;
      d.rise = 1'b1;
    end else begin
      d.cnt = s.cnt + PS_W'(1);
      d.fall = (s.cnt == (top >> 1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  assign cv.rise = s.rise;
  assign cv.fall = s.fall;

endmodule

// file: rtl/sac_sar.sv
`timescale 1ns/1ns
module sac_sar
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_ni,
  sac_conv_if.sar cv
);

  typedef struct packed {
    logic [RES_W-1:0] code;
    logic [RES_W-1:0] trial;
  } sac_sar_t;

  sac_sar_t s;
  sac_sar_t d;

  // ==========================================================
  // Binary search, one bit per step, MSB first
  always_comb begin
    d = s;
    if (cv.load) begin
      d.code = '0;
      d.trial = {1'b1, {(RES_W-1){1'b0}}};
    end else if (cv.step) begin
      d.code = s.code | (cv.cmp ? s.trial : '0);
      d.trial = s.trial >> 1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  // Trial value to the DAC; the result once trial is empty
  assign cv.code = s.code | s.trial;

endmodule

// file: rtl/sac_ctrl.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic cmp_i,
  input wire logic sleep_quiet_i,
  input wire logic global_irq_enable_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  output logic converter_on_o,
  output logic adc_clk_o,
  output logic sample_hold_o,
  output logic [sac_pkg::RES_W-1:0] dac_code_o,
  output logic [1:0] ref_select_o,
  output logic [2:0] input_select_o
);

  localparam logic [7:0] A_RES_LO = 8'(IDX_RES_LO * ADDR_STEP);
  localparam logic [7:0] A_RES_HI = 8'(IDX_RES_HI * ADDR_STEP);
  localparam logic [7:0] A_CSR = 8'(IDX_CSR * ADDR_STEP);
  localparam logic [7:0] A_MUX = 8'(IDX_MUX * ADDR_STEP);

  typedef struct packed {
    sac_state_t st;
    logic [4:0] cyc;
    logic ext;
    logic ext_pend;
    logic on;
    logic go;
    logic free;
    logic done;
    logic ie;
    logic [2:0] ps;
    logic [1:0] ref_sw;
    logic lj;
    logic [2:0] sel_sw;
    logic [1:0] ref_eff;
    logic [2:0] sel_eff;
    logic [RES_W-1:0] result;
    logic sleep_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic aclk;
    logic sh;
    logic [RES_W-1:0] dac;
    logic load;
    logic step;
  } sac_ctrl_t;

  sac_ctrl_t s;
  sac_ctrl_t d;
  logic [1:0] rsync;
  logic rst_n;
  logic setup;
  logic wr;
  logic fin;
  logic [4:0] shc;
  logic [4:0] len;
  logic [4:0] n;
  logic [7:0] csr_rd;
  logic [7:0] mux_rd;

  sac_conv_if cv ();

  // ==========================================================
  // Reset release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end

  assign rst_n = rsync[1];

  // ==========================================================
  // Converter clock and approximation register
  sac_prescaler u_pre (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .cv(cv.pre)
  );

  sac_sar u_sar (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .cv(cv.sar)
  );

  assign cv.en = s.on;
  assign cv.sel = s.ps;
  assign cv.load = s.load;
  assign cv.step = s.step;
  assign cv.cmp = cmp_i;

  // ==========================================================
  // Register read views
  always_comb begin
    csr_rd = CSR_RST;
    csr_rd[CSR_ON] = s.on;
    csr_rd[CSR_GO] = s.go;
    csr_rd[CSR_FREE] = s.free;
    csr_rd[CSR_DONE] = s.done;
    csr_rd[CSR_IE] = s.ie;
    csr_rd[CSR_PS_HI:0] = s.ps;
    mux_rd = MUX_RST;
    mux_rd[MUX_REF_HI:MUX_REF_LO] = s.ref_sw;
    mux_rd[MUX_LJ] = s.lj;
    mux_rd[MUX_SEL_HI:0] = s.sel_sw;
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = s;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.load = 1'b0;
    d.step = 1'b0;
    d.sh = 1'b0;
    setup = psel_i & ~penable_i;
    wr = psel_i & penable_i & s.pready & pwrite_i;
    shc = s.ext ? 5'(EXT_SH) : 5'(NORM_SH);
    len = s.ext ? 5'(EXT_LEN) : 5'(NORM_LEN);
    n = s.cyc + 5'h01;
    fin = 1'b0;

    // Bus answer prepared in setup, shown in access
    if (setup) begin
      d.pready = 1'b1;
      d.prdata = '0;
      case (paddr_i)
        A_CSR: begin
          d.prdata[7:0] = csr_rd;
        end
        A_MUX: begin
          d.prdata[7:0] = mux_rd;
        end
        A_RES_HI: begin
          if (s.lj) begin
            d.prdata[7:0] = s.result[RES_W-1:2];
          end else begin
            d.prdata[1:0] = s.result[RES_W-1:8];
          end
        end
        A_RES_LO: begin
          if (s.lj) begin
            d.prdata[7:6] = s.result[1:0];
          end else begin
            d.prdata[7:0] = s.result[7:0];
          end
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end

    // Conversion sequencing
    if (s.st == SAC_RUN) begin
      if (cv.fall && s.cyc == shc) begin
        d.sh = 1'b1;
      end
      if (cv.rise) begin
        if (n == len) begin
          fin = 1'b1;
        end else begin
          d.cyc = n;
          if (n > shc && n <= shc + 5'(RES_W)) begin
            d.step = 1'b1;
          end
        end
      end
    end

    if (fin) begin
      d.result = cv.code;
      d.st = SAC_IDLE;
      if (!s.free) begin
        d.go = 1'b0;
      end
    end

    // Software writes
    if (wr && paddr_i == A_CSR) begin
      d.on = pwdata_i[CSR_ON];
      d.go = d.go | pwdata_i[CSR_GO];
      d.free = pwdata_i[CSR_FREE];
      d.ie = pwdata_i[CSR_IE];
      d.ps = pwdata_i[CSR_PS_HI:0];
      if (pwdata_i[CSR_DONE]) begin
        d.done = 1'b0;
      end
    end
    if (wr && paddr_i == A_MUX) begin
      d.ref_sw = pwdata_i[MUX_REF_HI:MUX_REF_LO];
      d.lj = pwdata_i[MUX_LJ];
      d.sel_sw = pwdata_i[MUX_SEL_HI:0];
    end

    if (irq_ack_i) begin
      d.done = 1'b0;
    end
    if (fin) begin
      d.done = 1'b1;
    end

    // Quiet sleep launch
    if (sleep_quiet_i && !s.sleep_prev && s.on && !s.go && !s.free
        && s.ie && s.st == SAC_IDLE) begin
      d.go = 1'b1;
    end
    d.sleep_prev = sleep_quiet_i;

    // Selections take effect only between conversions
    if (d.on && d.st == SAC_IDLE) begin
      if (d.ref_sw != s.ref_eff) begin
        d.ext_pend = 1'b1;
      end
      if (d.sel_sw[MUX_SEL_HI] && !s.sel_eff[MUX_SEL_HI]) begin
        d.ext_pend = 1'b1;
      end
      d.ref_eff = d.ref_sw;
      d.sel_eff = d.sel_sw;
    end
    if (d.on && !s.on) begin
      d.ext_pend = 1'b1;
    end

    // Start on a converter clock rising edge
    if (d.on && d.go && d.st == SAC_IDLE && cv.rise) begin
      d.st = SAC_RUN;
      d.cyc = 5'h00;
      d.load = 1'b1;
      d.ext = d.ext_pend;
      d.ext_pend = 1'b0;
    end

    // Switch-off aborts
    if (!d.on) begin
      d.st = SAC_IDLE;
      d.go = 1'b0;
      d.cyc = 5'h00;
      d.aclk = 1'b0;
    end else if (cv.rise) begin
      d.aclk = 1'b1;
    end else if (cv.fall) begin
      d.aclk = 1'b0;
    end

    d.dac = cv.code;
    d.irq = d.done & d.ie & global_irq_enable_i;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign irq_o = s.irq;
  assign converter_on_o = s.on;
  assign adc_clk_o = s.aclk;
  assign sample_hold_o = s.sh;
  assign dac_code_o = s.dac;
  assign ref_select_o = s.ref_eff;
  assign input_select_o = s.sel_eff;

endmodule

// file: sim/sac_ctrl_sva.sv
`timescale 1ns/1ns
module sac_ctrl_sva
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_o,
  input wire logic converter_on_o,
  input wire logic adc_clk_o,
  input wire logic sample_hold_o
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ====================
  // Converter clock phase lengths
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= adc_clk_o ? hi_cnt + 8'h01 : 8'h00;
      lo_cnt <= (converter_on_o && !adc_clk_o) ? lo_cnt + 8'h01 : 8'h00;
    end
  end
  // ====================
  // Properties
  AST_ON_WRITE: assert property (
    pready_o && psel_i && pwrite_i && paddr_i == 8'h18
    |=> converter_on_o == $past(pwdata_i[7]))
    else $error("converter on bit not applied");
  AST_OFF_CLK: assert property (!converter_on_o ##1 !converter_on_o |-> !adc_clk_o)
    else $error("converter clock runs while off");
  AST_SH_ON: assert property (sample_hold_o |-> $past(converter_on_o))
    else $error("sample while converter off");
  AST_SH_PULSE: assert property (sample_hold_o |=> !sample_hold_o [*3])
    else $error("sample pulse too long");
  AST_IRQ_GATE: assert property (!global_irq_enable_i |=> !irq_o)
    else $error("interrupt without global enable");
  AST_HI_MAX: assert property (hi_cnt <= 8'h40)
    else $error("converter clock high too long");
  AST_LO_MAX: assert property (lo_cnt <= 8'h82)
    else $error("converter clock low too long");
  AST_RISE_ON: assert property ($rose(adc_clk_o) |-> converter_on_o)
    else $error("converter clock rise while off");
  COV_SAMPLE: cover property (sample_hold_o);
  COV_IRQ: cover property ($rose(irq_o));
  COV_ERR: cover property (pslverr_o);
endmodule

bind sac_ctrl sac_ctrl_sva chk_i (
  .clk_i, .nrst_i, .psel_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
  .global_irq_enable_i, .irq_o, .converter_on_o, .adc_clk_o, .sample_hold_o
);

// file: sim/tb_sar_adc_conversion_control.sv
`timescale 1ns/1ns
module tb_sar_adc_conversion_control;
  import sac_pkg::*;
  logic clk_i = 1'h0, nrst_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic cmp_i = 1'h0, sleep_quiet_i = 1'h0, global_irq_enable_i = 1'h1, irq_ack_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, irq_o, converter_on_o, adc_clk_o, sample_hold_o, se;
  logic [9:0] dac_code_o;
  logic [1:0] ref_select_o;
  logic [2:0] input_select_o;
  int num_errors = 0, n_tests = 0, n, i;
  always #50 clk_i = ~clk_i;
  // Comparator for a fixed input of 0x2A5
  always @(posedge clk_i) cmp_i <= 10'h2A5 >= dac_code_o;
  sac_ctrl dut (
    .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .cmp_i, .sleep_quiet_i, .global_irq_enable_i, .irq_ack_i,
    .irq_o, .converter_on_o, .adc_clk_o, .sample_hold_o, .dac_code_o, .ref_select_o,
    .input_select_o
  );
  // ====================
  // Tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'h1 && k < 20);
    if (k >= 20) begin
      num_errors++;
    end
    rd = prdata_o;
    se = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 8'h00);
    chk(rd, e);
  endtask
  task wirq(output int k);
    k = 0;
    while (irq_o !== 1'h1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) begin
      num_errors++;
    end
  endtask
  task wv(input logic v, inout int k);
    while (adc_clk_o !== v && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 300) begin
      num_errors++;
    end
  endtask
  // Cycles to sample pulse within lo..hi, then 11.5 converter cycles to done
  task conv(input int lo, input int hi);
    int k;
    k = 0;
    while (sample_hold_o !== 1'h1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    chk(k >= lo && k <= hi, 1'h1);
    wirq(k);
    chk(k >= 44 && k <= 50, 1'h1);
  endtask
  task t_div;
    for (i = 0; i < 8; i++) begin
      apb(1'h1, 8'h18, 8'h80 | 8'(i));
      n = 0;
      wv(1'h0, n);
      wv(1'h1, n);
      n = 0;
      wv(1'h0, n);
      wv(1'h1, n);
      chk(n, i < 2 ? 2 : 1 << i);
    end
    $display("divider test finished");
  endtask
  task t_single;
    apb(1'h1, 8'h18, 8'h02);
    apb(1'h1, 8'h18, 8'h82);
    apb(1'h1, 8'h1C, 8'h02);
    apb(1'h1, 8'h18, 8'hCA);
    conv(52, 61);
    rchk(8'h10, 8'hA5);
    rchk(8'h14, 8'h02);
    rchk(8'h18, 8'h9A);
    chk(irq_o, 1'h1);
    global_irq_enable_i <= 1'h0;
    cyc(2);
    chk(irq_o, 1'h0);
    global_irq_enable_i <= 1'h1;
    cyc(2);
    chk(irq_o, 1'h1);
    apb(1'h1, 8'h1C, 8'h22);
    rchk(8'h14, 8'hA9);
    rchk(8'h10, 8'h40);
    irq_ack_i <= 1'h1;
    @(posedge clk_i);
    irq_ack_i <= 1'h0;
    cyc(3);
    chk(irq_o, 1'h0);
    rchk(8'h18, 8'h8A);
    apb(1'h1, 8'h18, 8'hCA);
    conv(4, 13);
    $display("single test finished");
  endtask
  task t_defer;
    apb(1'h1, 8'h18, 8'hDA);
    cyc(12);
    apb(1'h1, 8'h1C, 8'hC3);
    chk(ref_select_o, 2'h0);
    chk(input_select_o, 3'h2);
    wirq(n);
    cyc(2);
    chk(ref_select_o, 2'h3);
    chk(input_select_o, 3'h3);
    apb(1'h1, 8'h18, 8'hDA);
    conv(52, 61);
    apb(1'h1, 8'h18, 8'h9A);
    for (i = 0; i < 8; i++) begin
      apb(1'h1, 8'h1C, {i[1:0], 3'h0, i[2:0]});
      cyc(2);
      chk(ref_select_o, i[1:0]);
      chk(input_select_o, i[2:0]);
    end
    $display("select test finished");
  endtask
  task t_free;
    apb(1'h1, 8'h18, 8'hEA);
    wirq(n);
    apb(1'h1, 8'h18, 8'hFA);
    chk(irq_o, 1'h0);
    wirq(n);
    chk(n < 60, 1'h1);
    rchk(8'h18, 8'hFA);
    apb(1'h1, 8'h18, 8'h9A);
    wirq(n);
    cyc(60);
    rchk(8'h18, 8'h9A);
    $display("free test finished");
  endtask
  task t_abort;
    apb(1'h1, 8'h18, 8'hDA);
    cyc(20);
    apb(1'h1, 8'h18, 8'h0A);
    cyc(2);
    chk({converter_on_o, adc_clk_o}, 2'h0);
    cyc(150);
    rchk(8'h18, 8'h0A);
    apb(1'h1, 8'h18, 8'h8A);
    cyc(150);
    chk(irq_o, 1'h0);
    sleep_quiet_i <= 1'h1;
    wirq(n);
    chk(n < 150, 1'h1);
    sleep_quiet_i <= 1'h0;
    $display("abort and sleep test finished");
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ====================
  // Sequence
  initial begin
    cyc(12);
    nrst_i <= 1'h1;
    cyc(3);
    rchk(8'h18, 8'h00);
    rchk(8'h1C, 8'h00);
    rchk(8'h20, 8'h00);
    chk(se, 1'h1);
    t_div;
    t_single;
    t_defer;
    t_free;
    t_abort;
    end_of_test;
  end
  initial begin
    #3000000;
    num_errors++;
    end_of_test;
  end
endmodule
